// file: hdl/cancx_consts.svh
// Register offsets, field positions and reset values of the CAN host interface
`ifndef CANCX_CONSTS_SVH
`define CANCX_CONSTS_SVH
// ==========================================================================
// Register offsets
`define CANCX_CFG_OFS      8'h92
`define CANCX_CTL_OFS      8'h80
`define CANCX_STA_OFS      8'h81
`define CANCX_TST_OFS      8'h82
`define CANCX_ERR_OFS      8'h83
`define CANCX_BTL_OFS      8'h85
`define CANCX_BTH_OFS      8'h86
`define CANCX_BRPE_OFS     8'h87
`define CANCX_IF1_BASE     8'hA0
`define CANCX_IF2_BASE     8'hB0
`define CANCX_MH_BASE      8'hC0
// ==========================================================================
// Reset values and masks
`define CANCX_CFG_RST      8'h00
`define CANCX_CFG_MASK     8'h03
`define CANCX_CTL_RST      8'h01
`define CANCX_BT_RST       8'h00
// ==========================================================================
// Field positions
`define CANCX_CTL_INIT     0
`define CANCX_STA_TXOK     3
`define CANCX_STA_RXOK     4
`define CANCX_CMD_BUSY     7
`define CANCX_MSK_WR       7
`define CANCX_MSK_CLRINT   3
`define CANCX_MSK_CLRND    2
`define CANCX_W_ID_HI      28
`define CANCX_W_DIR        29
`define CANCX_W_XTD        30
`define CANCX_W_VLD        31
`define CANCX_W_MSK_LO     32
`define CANCX_W_DLC_LO     64
`define CANCX_W_TXR        70
`define CANCX_W_NDAT       71
`define CANCX_W_DATA_LO    72
`endif

// file: hdl/cancx_pkg.sv
// Types shared by the CAN host interface modules
package cancx_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cancx_sfr_req_t;

  typedef struct packed {
    logic        xtd;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [31:0] data;
  } cancx_frame_t;

  typedef enum logic [2:0] {
    MH_IDLE,
    MH_XFER,
    MH_RXSCAN,
    MH_TXSCAN,
    MH_TXWAIT
  } cancx_mh_state_t;
endpackage

// file: hdl/cancx_clkdiv.sv
// Controller clock enable divider
`timescale 1ns/1ps
`include "cancx_consts.svh"
module cancx_clkdiv (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [1:0] sel,
  output logic            ce
);
  logic [2:0] cnt;
  logic [2:0] lim;

  // Divide codes 00..11 give /1, /2, /4, /8
  assign lim = (sel == 2'h0) ? 3'h0 : (sel == 2'h1) ? 3'h1 : (sel == 2'h2) ? 3'h3 : 3'h7;

  // Enable pulse instead of a divided clock, so a divider change never makes a runt
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt <= 3'h0;
      ce  <= 1'b0;
    end else begin
      cnt <= (cnt >= lim) ? 3'h0 : cnt + 3'h1;
      ce  <= (cnt >= lim);
    end
  end
endmodule

// file: hdl/cancx_host_if.sv
// CAN controller host interface: registers, message memory and message handler
`timescale 1ns/1ps
`include "cancx_consts.svh"
// Function
// - The controller clock is the system clock divided by 1, 2, 4 or 8 as the divide select says.
// - The upper six bits of the clock configuration register read zero and ignore writes.
// - The controller handles bus bit rates up to 1 Mbit/s, limited further by the transceiver.
// - Both standard and extended identifier frames are handled.
// - There are 32 message objects, each set independently to transmit or receive.
// - Data, object setup and masks live in a private message memory.
// - Transmission and acceptance filtering run with no processor help, and no bus drivers.
// - Two independent interface register sets configure objects and move their data.
// - The processor reaches message memory only by writing an object number to a command register.
// - Each object holds an identifier used for acceptance filtering.
// - Read-only handler registers show valid, transmit request, new data and pending flags.
// - Protocol registers give control, status, error count, bit timing, prescaler and test.
module cancx_host_if (
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire cancx_pkg::cancx_sfr_req_t sfr_req,
  output logic [7:0]                  sfr_rdata,
  input  wire cancx_pkg::cancx_frame_t rx_frame,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  output cancx_pkg::cancx_frame_t     tx_frame,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  input  wire logic                   link_err
);
  import cancx_pkg::*;

  // ========================================================================
  // Storage
  logic [7:0]      cfg;
  logic [7:0]      ctl;
  logic [7:0]      sta;
  logic [7:0]      tst;
  logic [15:0]     err_cnt;
  logic [7:0]      btl;
  logic [7:0]      bth;
  logic [7:0]      brpe;
  logic [7:0]      ifr [2][16];
  logic [103:0]    ram [32];
  logic [31:0]     vld;
  logic [31:0]     txr;
  logic [31:0]     ndat;
  logic [31:0]     intpnd;
  cancx_mh_state_t state;
  logic [4:0]      ptr;
  logic            set_sel;
  logic            rx_pend;
  cancx_frame_t    rx_buf;
  logic            can_ce;

  // Set s decodes to base + 0..15
  function automatic logic set_hit(input logic [7:0] a, input logic [7:0] base);
    set_hit = (a[7:4] == base[7:4]);
  endfunction

  // Pack bytes 2..14 of an interface set into one memory word
  function automatic logic [103:0] pack_set(input logic s);
    logic [103:0] w;
    w = '0;
    for (int k = 0; k < 13; k++) begin
      w[k*8 +: 8] = ifr[s][k+2];
    end
    pack_set = w;
  endfunction

  // ========================================================================
  // Controller clock enable
  cancx_clkdiv u_div (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .sel     (cfg[1:0]),
    .ce      (can_ce)
  );

  // ========================================================================
  // Address decode and read mux
  logic        wr;
  logic [7:0]  a;
  logic        hit1;
  logic        hit2;
  logic        hit_mh;
  logic [31:0] mh_word;
  logic [7:0]  mh_byte;
  logic [7:0]  next_rdata;
  logic        init;
  logic [1:0]  busy;
  logic [103:0] cur;
  logic        cur_vld;
  logic        rx_match;
  logic        tx_cand;
  logic [28:0] msk;
  logic [28:0] idm;

  assign wr     = sfr_req.wr;
  assign a      = sfr_req.addr;
  assign hit1   = set_hit(a, `CANCX_IF1_BASE);
  assign hit2   = set_hit(a, `CANCX_IF2_BASE);
  assign hit_mh = set_hit(a, `CANCX_MH_BASE);
  assign init   = ctl[`CANCX_CTL_INIT];
  assign busy   = {ifr[1][0][`CANCX_CMD_BUSY], ifr[0][0][`CANCX_CMD_BUSY]};
  // Handler flags are read-only; bytes 0..3 valid, 4..7 txreq, 8..11 new, 12..15 pending
  assign mh_word = (a[3:2] == 2'h0) ? vld : (a[3:2] == 2'h1) ? txr :
                   (a[3:2] == 2'h2) ? ndat : intpnd;
  assign mh_byte = mh_word[a[1:0]*8 +: 8];
  assign next_rdata =
      (a == `CANCX_CFG_OFS)  ? (cfg & `CANCX_CFG_MASK) :
      (a == `CANCX_CTL_OFS)  ? ctl :
      (a == `CANCX_STA_OFS)  ? sta :
      (a == `CANCX_TST_OFS)  ? tst :
      (a == `CANCX_ERR_OFS)  ? err_cnt[7:0] :
      (a == `CANCX_ERR_OFS + 8'h01) ? err_cnt[15:8] :
      (a == `CANCX_BTL_OFS)  ? btl :
      (a == `CANCX_BTH_OFS)  ? bth :
      (a == `CANCX_BRPE_OFS) ? brpe :
      hit1   ? ifr[0][a[3:0]] :
      hit2   ? ifr[1][a[3:0]] :
      hit_mh ? mh_byte : 8'h00; // Unmapped reads return zero

  // Acceptance filter on the object under the scan pointer
  assign cur      = ram[ptr];
  assign cur_vld  = vld[ptr];
  assign msk      = cur[`CANCX_W_MSK_LO +: 29];
  assign idm      = cur[28:0];
  assign rx_match = cur_vld & ~cur[`CANCX_W_DIR] & (cur[`CANCX_W_XTD] == rx_buf.xtd) &
                    ((idm & msk) == (rx_buf.id & msk));
  assign tx_cand  = cur_vld & cur[`CANCX_W_DIR] & txr[ptr];

  // ========================================================================
  // Protocol registers; hardware status set wins over a software write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg     <= `CANCX_CFG_RST;
      ctl     <= `CANCX_CTL_RST;
      sta     <= 8'h00;
      tst     <= 8'h00;
      err_cnt <= 16'h0000;
      btl     <= `CANCX_BT_RST;
      bth     <= `CANCX_BT_RST;
      brpe    <= `CANCX_BT_RST;
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= sfr_req.rd ? next_rdata : 8'h00;
      if (wr && a == `CANCX_CFG_OFS) cfg <= sfr_req.wdata & `CANCX_CFG_MASK;
      if (wr && a == `CANCX_CTL_OFS) ctl <= sfr_req.wdata;
      if (wr && a == `CANCX_TST_OFS) tst <= sfr_req.wdata;
      if (wr && a == `CANCX_BTL_OFS) btl <= sfr_req.wdata;
      if (wr && a == `CANCX_BTH_OFS) bth <= sfr_req.wdata;
      if (wr && a == `CANCX_BRPE_OFS) brpe <= sfr_req.wdata;
      if (link_err && err_cnt != 16'hFFFF) err_cnt <= err_cnt + 16'h0001;
      sta <= ((wr && a == `CANCX_STA_OFS) ? sfr_req.wdata : sta) |
             {3'h0, state == MH_RXSCAN && can_ce && rx_match,
              state == MH_TXWAIT && tx_ready, 3'h0};
    end
  end

  // ========================================================================
  // Message handler: interface transfers first, then receive, then transmit.
  // Scans walk one object per controller clock, so the handler never needs
  // 32 parallel comparators; the trade is up to 32 controller clocks per frame.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state    <= MH_IDLE;
      ptr      <= 5'h00;
      set_sel  <= 1'b0;
      rx_pend  <= 1'b0;
      rx_buf   <= '0;
      rx_ready <= 1'b0;
      tx_frame <= '0;
      tx_valid <= 1'b0;
      vld      <= 32'h0;
      txr      <= 32'h0;
      ndat     <= 32'h0;
      intpnd   <= 32'h0;
      for (int s = 0; s < 2; s++) begin
        for (int k = 0; k < 16; k++) begin
          ifr[s][k] <= 8'h00;
        end
      end
    end else begin
      // Software writes to the interface sets; a command write marks the set busy
      for (int s = 0; s < 2; s++) begin
        if (wr && (s == 0 ? hit1 : hit2)) begin
          if (a[3:0] == 4'h0) begin
            ifr[s][0] <= {1'b1, 2'h0, sfr_req.wdata[4:0]};
          end else if (!busy[s]) begin
            ifr[s][a[3:0]] <= sfr_req.wdata;
          end
        end
      end
      rx_ready <= (state == MH_IDLE) & ~rx_pend & ~init & ~(rx_valid & rx_ready);
      if (rx_valid && rx_ready) begin
        rx_buf  <= rx_frame;
        rx_pend <= 1'b1;
      end
      case (state)
        MH_IDLE: begin
          ptr <= 5'h00;
          if (busy[0] || busy[1]) begin
            set_sel <= ~busy[0];
            state   <= MH_XFER;
          end else if (!init && can_ce && rx_pend) begin
            state <= MH_RXSCAN;
          end else if (!init && can_ce && |(txr & vld)) begin
            state <= MH_TXSCAN;
          end
        end
        MH_XFER: begin
          // Copy between the set and the addressed object, then drop busy
          if (ifr[set_sel][1][`CANCX_MSK_WR]) begin
            ram[ifr[set_sel][0][4:0]]    <= pack_set(set_sel);
            vld[ifr[set_sel][0][4:0]]    <= ifr[set_sel][5][7];
            txr[ifr[set_sel][0][4:0]]    <= ifr[set_sel][10][6];
            ndat[ifr[set_sel][0][4:0]]   <= ifr[set_sel][10][7];
          end else begin
            for (int k = 0; k < 13; k++) begin
              ifr[set_sel][k+2] <= ram[ifr[set_sel][0][4:0]][k*8 +: 8];
            end
            ifr[set_sel][5][7]  <= vld[ifr[set_sel][0][4:0]];
            ifr[set_sel][10][6] <= txr[ifr[set_sel][0][4:0]];
            ifr[set_sel][10][7] <= ndat[ifr[set_sel][0][4:0]];
            if (ifr[set_sel][1][`CANCX_MSK_CLRND]) ndat[ifr[set_sel][0][4:0]] <= 1'b0;
          end
          if (ifr[set_sel][1][`CANCX_MSK_CLRINT]) intpnd[ifr[set_sel][0][4:0]] <= 1'b0;
          // A fresh command to this set in the same cycle keeps its busy bit
          if (!(wr && a[3:0] == 4'h0 && (set_sel ? hit2 : hit1))) begin
            ifr[set_sel][0][`CANCX_CMD_BUSY] <= 1'b0;
          end
          state <= MH_IDLE;
        end
        MH_RXSCAN: begin
          if (can_ce) begin
            if (rx_match) begin
              ram[ptr][`CANCX_W_DATA_LO +: 32] <= rx_buf.data;
              ram[ptr][`CANCX_W_DLC_LO +: 4]   <= rx_buf.dlc;
              ndat[ptr]   <= 1'b1;
              intpnd[ptr] <= 1'b1;
            end
            ptr <= ptr + 5'h01;
            if (rx_match || ptr == 5'h1F) begin
              rx_pend <= 1'b0; // Unmatched frames are dropped after a full scan
              state   <= MH_IDLE;
            end
          end
        end
        MH_TXSCAN: begin
          if (can_ce) begin
            if (tx_cand) begin
              tx_frame <= '{xtd: cur[`CANCX_W_XTD], id: idm, dlc: cur[`CANCX_W_DLC_LO +: 4],
                            data: cur[`CANCX_W_DATA_LO +: 32]};
              tx_valid <= 1'b1;
              state    <= MH_TXWAIT;
            end else begin
              ptr <= ptr + 5'h01;
              if (ptr == 5'h1F) state <= MH_IDLE;
            end
          end
        end
        MH_TXWAIT: begin
          // Lowest-numbered pending object goes first; frame held until the link takes it
          if (tx_ready) begin
            tx_valid    <= 1'b0;
            txr[ptr]    <= 1'b0;
            intpnd[ptr] <= 1'b1;
            state       <= MH_IDLE;
          end
        end
        default: state <= MH_IDLE;
      endcase
    end
  end
endmodule

// file: verification/cancx_host_if_props.sv
// Port checks for the CAN host interface
`timescale 1ns/1ps
module cancx_host_if_props (
  input wire logic                     clk_sys,
  input wire logic                     sys_rst,
  input wire cancx_pkg::cancx_sfr_req_t sfr_req,
  input wire logic [7:0]               sfr_rdata,
  input wire logic                     rx_valid,
  input wire logic                     rx_ready,
  input wire cancx_pkg::cancx_frame_t  tx_frame,
  input wire logic                     tx_valid,
  input wire logic                     tx_ready
);
  import cancx_pkg::*;
  logic [1:0] cfg_q;
  logic       init_q;
  // =====
  // Shadow of divide select and init bit, as references for the read-back and init checks
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_q <= 2'h0;
      init_q <= 1'b1;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == 8'h92) cfg_q <= sfr_req.wdata[1:0];
      if (sfr_req.addr == 8'h80) init_q <= sfr_req.wdata[0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // =====
  // Assertions
  a_rdata_idle_zero: assert property (!sfr_req.rd |=> sfr_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_cfg_read_back: assert property (
    sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'h92 |=> sfr_rdata == {6'h00, cfg_q})
    else $error("divide select read back wrong");
  a_unmapped_zero: assert property (
    sfr_req.rd && sfr_req.addr == 8'h90 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_tx_frame_held: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("transmit offer changed before taken");
  a_tx_valid_drops: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("transmit offer stayed after take");
  a_rx_ready_drops: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("receive ready stayed after take");
  a_rx_ready_back: assert property (rx_valid && rx_ready |-> ##[2:800] rx_ready)
    else $error("receive ready never returned");
  a_init_blocks_rx: assert property (
    init_q && $past(init_q) && $past(init_q, 2) |-> !rx_ready)
    else $error("receive ready while in init");
  c_tx_take: cover property (tx_valid && tx_ready);
  c_tx_stall: cover property (tx_valid && !tx_ready);
  c_rx_take: cover property (rx_valid && rx_ready);
endmodule
bind cancx_host_if cancx_host_if_props u_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_frame(tx_frame),
  .tx_valid(tx_valid), .tx_ready(tx_ready));

// file: verification/cancx_link_model.sv
// Link-side partner: offers received frames, takes transmitted ones
`timescale 1ns/1ps
module cancx_link_model (
  input  wire logic                    clk_sys,
  input  wire logic                    slow,
  input  wire logic                    rx_ready,
  input  wire logic                    tx_valid,
  input  wire cancx_pkg::cancx_frame_t tx_frame,
  output cancx_pkg::cancx_frame_t      rx_frame,
  output logic                         rx_valid,
  output logic                         tx_ready,
  output logic                         link_err
);
  import cancx_pkg::*;
  cancx_frame_t got[$];
  initial begin
    rx_frame = '0;
    rx_valid = 1'b0;
    link_err = 1'b0;
  end
  // Stalls at random when slow, to test the hold of an offer
  always @(negedge clk_sys) tx_ready <= !slow || ($urandom_range(3) == 0);
  always @(posedge clk_sys) if (tx_valid && tx_ready) got.push_back(tx_frame);
  // Frame held until taken, then the lines show junk, not the old value
  task automatic send(input cancx_frame_t f);
    @(negedge clk_sys);
    rx_frame = f;
    rx_valid = 1'b1;
    do @(posedge clk_sys); while (!rx_ready);
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_frame = ~f;
  endtask
  task automatic bump;
    @(negedge clk_sys);
    link_err = 1'b1;
    @(negedge clk_sys);
    link_err = 1'b0;
  endtask
endmodule

// file: verification/test_can_controller_host_interface.sv
// Self-checking bench for the CAN host interface
`timescale 1ns/1ps
module test_can_controller_host_interface;
  import cancx_pkg::*;
  logic           clk_sys, sys_rst, rx_ready, rx_valid, tx_valid, tx_ready, link_err, slow;
  logic [7:0]     sfr_rdata, v;
  cancx_sfr_req_t sfr_req;
  cancx_frame_t   rx_frame, tx_frame, f;
  cancx_frame_t   exp_tx[$];
  int             miscompares = 0, checks = 0, cfg_m;
  time            t0;
  // =====
  // Clock and watchdog; the tests need a few hundred cycles
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    results;
  end
  cancx_host_if uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .rx_frame(rx_frame), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .link_err(link_err));
  cancx_link_model u_link (.clk_sys(clk_sys), .slow(slow), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_frame(tx_frame), .rx_frame(rx_frame), .rx_valid(rx_valid),
    .tx_ready(tx_ready), .link_err(link_err));
  // =====
  // Bus tasks; strobes rise and fall on falling edges
  task automatic results;
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [65:0] g, e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_sys);
    sfr_req = '{a, d, 1'b1, 1'b0};
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(negedge clk_sys);
    sfr_req = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge clk_sys);
    r = sfr_rdata;
    sfr_req.rd = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, e);
    rd(a, v);
    chk(v, e);
  endtask
  // Command an object copy, then poll busy under a bound
  task automatic go(input logic [7:0] b, input logic [4:0] n);
    wr(b, {3'h0, n});
    for (int t = 0; t < 40; t++) begin
      rd(b, v);
      if (!v[7]) break;
    end
    chk(v[7], 1'b0);
  endtask
  task automatic obj(input logic [7:0] b, input logic [4:0] n, input logic [2:0] fl,
                     input logic txr, input cancx_frame_t fr);
    wr(b + 8'h01, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(b + 8'h02 + 8'(i), 8'(fr.id >> (8 * i)) | (i == 3 ? {fl, 5'h00} : 8'h00));
      wr(b + 8'h06 + 8'(i), 8'hFF);
      wr(b + 8'h0B + 8'(i), 8'(fr.data >> (8 * i)));
    end
    wr(b + 8'h0A, {1'b0, txr, 2'b00, fr.dlc});
    go(b, n);
  endtask
  // Data bytes mirror, so byte order inside the word cannot matter
  function automatic cancx_frame_t mk(input logic x);
    logic [15:0] h;
    h = 16'($urandom);
    return '{x, 29'($urandom), 4'h4, {h, h[7:0], h[15:8]}};
  endfunction
  task automatic rx(input cancx_frame_t fr);
    u_link.send(fr);
    @(negedge clk_sys);
    for (int t = 0; t < 900 && !rx_ready; t++) @(negedge clk_sys);
  endtask
  // =====
  // Main sequence
  initial begin
    sfr_req = '0;
    sys_rst = 1'b1;
    slow = 1'b0;
    void'($urandom(31));
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    rc(8'h92, 8'h00);
    rc(8'h80, 8'h01);
    // Every divide code, noise in the read-only bits; ends on the slowest
    for (int k = 0; k < 4; k++) begin
      cfg_m = k;
      wr(8'h92, 8'($urandom) & 8'hFC | 8'(k));
      rc(8'h92, 8'(cfg_m));
    end
    wr(8'h90, 8'hFF);
    rc(8'h90, 8'h00);
    wr(8'hC0, 8'hFF);
    rc(8'hC0, 8'h00);
    // Test and bit timing registers keep what is written
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(i == 0 ? 8'h82 : 8'h84 + 8'(i), v);
      rc(i == 0 ? 8'h82 : 8'h84 + 8'(i), v);
    end
    wr(8'h80, 8'h00);
    f = mk(1'b0);
    obj(8'hA0, 5'd0, 3'b100, 1'b0, f);
    rc(8'hC0, 8'h01);
    // New payload, so the read-back proves the receive path wrote it
    f.data = ~f.data;
    rx(f);
    rc(8'hC8, 8'h01);
    rc(8'hCC, 8'h01);
    rd(8'h81, v);
    chk(v[4], 1'b1);
    wr(8'hB1, 8'h0C);
    go(8'hB0, 5'd0);
    rc(8'hCC, 8'h00);
    for (int i = 0; i < 4; i++) rc(8'hBB + 8'(i), 8'(f.data >> (8 * i)));
    rc(8'hC8, 8'h00);
    f.id = ~f.id;
    t0 = $time;
    rx(f);
    // A full scan at divide by 8 takes 32 objects of 8 system clocks
    chk(($time - t0) >= 960 && ($time - t0) <= 1120, 1'b1);
    rc(8'hC8, 8'h00);
    slow = 1'b1;
    f = mk(1'b1);
    exp_tx.push_back(f);
    obj(8'hB0, 5'd1, 3'b111, 1'b1, f);
    for (int t = 0; t < 900 && u_link.got.size() == 0; t++) @(negedge clk_sys);
    chk(u_link.got.size(), 1);
    if (u_link.got.size() > 0) chk(u_link.got[0], exp_tx[0]);
    rc(8'hC4, 8'h00);
    rc(8'hCC, 8'h02);
    rd(8'h81, v);
    chk(v[3], 1'b1);
    u_link.bump;
    rc(8'h83, 8'h01);
    results;
  end
endmodule
